/* File: spmsp_eng_if.sv */
/*
 * spmsp_eng_if: configuration, data and pin signals between the register
 * front end and the shift engine.
 * assumes: both ends run on the same clock.
 */
`timescale 1ns/1ps

interface spmsp_eng_if;
    logic       on;
    logic       master;
    logic       clock_idle_level;
    logic       sample_edge_select;
    logic       low_bit_first;
    logic [1:0] rate;
    logic       ss_ignore;
    logic       load;
    logic [7:0] load_data;
    logic       busy;
    logic       done;
    logic [7:0] rx_byte;
    logic       sck_s;
    logic       mosi_s;
    logic       miso_s;
    logic       ss_n_s;
    logic       sck_o;
    logic       sck_oe;
    logic       mosi_o;
    logic       mosi_oe;
    logic       miso_o;
    logic       miso_oe;

    modport ctl (
        output on, master, clock_idle_level, sample_edge_select, low_bit_first, rate, ss_ignore, load, load_data,
        output sck_s, mosi_s, miso_s, ss_n_s,
        input  busy, done, rx_byte, sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe
    );

    modport eng (
        input  on, master, clock_idle_level, sample_edge_select, low_bit_first, rate, ss_ignore, load, load_data,
        input  sck_s, mosi_s, miso_s, ss_n_s,
        output busy, done, rx_byte, sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe
    );
endinterface

/* File: spmsp_engine.sv */
/*
 * spmsp_engine: eight-bit shift engine, master clock generator and slave
 * edge follower.
 * assumes: pin inputs on the interface are already synchronised.
 */
`timescale 1ns/1ps
`include "spmsp_params.svh"

module spmsp_engine
    import spmsp_pkg::*;
(
    input  wire logic aclk,
    input  wire logic aresetn,
    input  wire logic ce,
    spmsp_eng_if.eng  e
);
    spmsp_eng_s eng_reg;
    spmsp_eng_s eng_next;

    function automatic logic head(input logic [7:0] v, input logic low_bit_first);
        return low_bit_first ? v[0] : v[7];
    endfunction

    logic       tick;
    logic       sel;
    logic       din;
    logic [3:0] half_m1;

    always_comb begin
        eng_next      = eng_reg;
        eng_next.done = 1'b0;
        tick          = 1'b0;
        sel           = !e.master && (e.ss_ignore || !e.ss_n_s);
        din           = e.master ? e.miso_s : e.mosi_s;
        half_m1       = 4'((4'd1 << e.rate) - 4'd1);
        if (!e.on) begin
            eng_next     = '0;
            eng_next.sck = e.clock_idle_level;
        end else begin
            if (e.load && eng_reg.state == ENG_IDLE) begin
                eng_next.tx = e.load_data;
                if (e.master) begin
                    eng_next.state   = ENG_RUN;
                    eng_next.div_cnt = half_m1;
                end
            end
            if (e.master) begin
                if (eng_reg.state == ENG_RUN) begin
                    if (eng_reg.div_cnt == 4'd0) begin
                        tick             = 1'b1;
                        eng_next.sck     = !eng_reg.sck;
                        eng_next.div_cnt = half_m1;
                    end else begin
                        eng_next.div_cnt = eng_reg.div_cnt - 4'd1;
                    end
                end else begin
                    eng_next.sck = e.clock_idle_level;
                end
            end else if (!sel) begin
                eng_next.state    = ENG_IDLE;
                eng_next.edge_cnt = 4'd0;
            end else if (e.sck_s != eng_reg.sck_prev &&
                         (eng_reg.state == ENG_RUN || e.sck_s != e.clock_idle_level)) begin
                tick = 1'b1;
            end
            eng_next.sck_prev = e.sck_s;
            if (tick) begin
                eng_next.state = ENG_RUN;
                if (eng_reg.edge_cnt[0] == e.sample_edge_select) begin
                    eng_next.rx = e.low_bit_first ? {din, eng_reg.rx[7:1]}
                                         : {eng_reg.rx[6:0], din};
                end else if (eng_reg.edge_cnt != 4'd0) begin
                    eng_next.tx = e.low_bit_first ? {1'b0, eng_reg.tx[7:1]}
                                         : {eng_reg.tx[6:0], 1'b0};
                end
                if (eng_reg.edge_cnt == `SPMSP_LAST_EDGE) begin
                    eng_next.state    = ENG_IDLE;
                    eng_next.edge_cnt = 4'd0;
                    eng_next.done     = 1'b1;
                    eng_next.rx_byte  = eng_next.rx;
                end else begin
                    eng_next.edge_cnt = eng_reg.edge_cnt + 4'd1;
                end
            end
        end
        eng_next.out_bit = head(eng_next.tx, e.low_bit_first);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            eng_reg <= '0;
        end else if (ce) begin
            eng_reg <= eng_next;
        end
    end

    assign e.busy    = (eng_reg.state == ENG_RUN);
    assign e.done    = eng_reg.done;
    assign e.rx_byte = eng_reg.rx_byte;
    assign e.sck_o   = eng_reg.sck;
    assign e.sck_oe  = e.on && e.master;
    assign e.mosi_o  = eng_reg.out_bit;
    assign e.mosi_oe = e.on && e.master;
    assign e.miso_o  = eng_reg.out_bit;
    assign e.miso_oe = e.on && sel;
endmodule // spmsp_engine

/* File: spmsp_monitor.sv */
/* spmsp_monitor: bus handshake and pin enable checks on the serial port.
   assumes: bound to spmsp_top, one clock, synchronous active low reset. */
`timescale 1ns/1ps
module spmsp_monitor (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic        sck_oe,
    input wire logic        mosi_oe,
    input wire logic        miso_oe
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    property p_oe; sck_oe |-> mosi_oe && !miso_oe; endproperty
    a_oe: assert property (p_oe) else $error("master enables wrong");
    property p_oe_back; mosi_oe |-> sck_oe; endproperty
    a_oe_back: assert property (p_oe_back) else $error("data enable alone");
    property p_w_refuse; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
    a_w_refuse: assert property (p_w_refuse) else $error("write taken early");
    property p_ar_refuse; s_axi_rvalid |-> !s_axi_arready; endproperty
    a_ar_refuse: assert property (p_ar_refuse) else $error("read taken early");
    property p_b_once; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
    a_b_once: assert property (p_b_once) else $error("write answer repeated");
    property p_r_once; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid; endproperty
    a_r_once: assert property (p_r_once) else $error("read answer repeated");
    property p_rd_hi; s_axi_rvalid |-> s_axi_rdata[31:8] == '0; endproperty
    a_rd_hi: assert property (p_rd_hi) else $error("read upper bits set");
    property p_ar_open; $fell(s_axi_rvalid) |-> s_axi_arready; endproperty
    a_ar_open: assert property (p_ar_open) else $error("read slot stays shut");
endmodule // spmsp_monitor
bind spmsp_top spmsp_monitor spmsp_monitor_inst (.*);

/* File: spmsp_params.svh */
/*
 * spmsp_params.svh: register indices, field positions, reset values and counts
 * for the serial port block.
 * assumes: included by its bare name from the engine and the top module.
 */
`ifndef SPMSP_PARAMS_SVH
`define SPMSP_PARAMS_SVH

////////////////////////////////////////////////////////////////////////////////
// register indices, byte address is four times the index
`define SPMSP_IDX_IRQ_GLOBAL 8'hA8
`define SPMSP_IDX_IRQ_EN     8'hA9
`define SPMSP_IDX_PRIO_LO    8'hBA
`define SPMSP_IDX_PRIO_HI    8'hBB
`define SPMSP_IDX_CTRL       8'hBC
`define SPMSP_IDX_STAT       8'hBD
`define SPMSP_IDX_DATA       8'hBE

////////////////////////////////////////////////////////////////////////////////
// control fields
`define SPMSP_CTRL_ON        7
`define SPMSP_CTRL_ROLE      6
`define SPMSP_CTRL_CLOCK_IDLE_LEVEL      5
`define SPMSP_CTRL_SAMPLE_EDGE_SELECT      4
`define SPMSP_CTRL_SSIGN     3
`define SPMSP_CTRL_LOW_BIT_FIRST      2
`define SPMSP_CTRL_RATE_HI   1
`define SPMSP_CTRL_RATE_LO   0

// status fields
`define SPMSP_STAT_DONE      7
`define SPMSP_STAT_WRITE_COLLISION_FLAG      6
`define SPMSP_STAT_MODE_FAULT_FLAG      5
`define SPMSP_STAT_OVF       4
`define SPMSP_STAT_FULL      3
`define SPMSP_STAT_BUSY      2

// interrupt fields
`define SPMSP_GIE_BIT        7
`define SPMSP_IRQ_BIT        4

////////////////////////////////////////////////////////////////////////////////
// reset values, counts and bus response codes
`define SPMSP_RST_BYTE       8'h00
`define SPMSP_LAST_EDGE      4'hF
`define SPMSP_RESP_OKAY      2'b00
`define SPMSP_RESP_SLVERR    2'b10

`endif

/* File: spmsp_peer.sv */
/* spmsp_peer: slave device on the serial pins, clock idle low, msb first.
   assumes: the port under test is master and makes the serial clock. */
`timescale 1ns/1ps
module spmsp_peer (
    input  wire logic       sck,
    input  wire logic       mosi,
    input  wire logic       sel_n,
    input  wire logic [7:0] tx,
    output logic            miso,
    output logic [7:0]      rx
);
    logic [7:0] sh_reg;
    initial miso = 1'b0;
    always @(negedge sel_n) begin
        sh_reg = tx;
        miso = tx[7];
    end
    always @(posedge sel_n) miso = ~miso;
    always @(posedge sck) if (!sel_n) rx = {rx[6:0], mosi};
    always @(negedge sck) if (!sel_n) begin
        sh_reg = {sh_reg[6:0], 1'b0};
        miso = sh_reg[7];
    end
endmodule // spmsp_peer

/* File: spmsp_pkg.sv */
/*
 * spmsp_pkg: state types of the serial port block.
 * assumes: spmsp_params.svh on the include path.
 */
package spmsp_pkg;

    typedef enum logic {
        ENG_IDLE,
        ENG_RUN
    } spmsp_eng_state_e;

    typedef struct packed {
        spmsp_eng_state_e state;
        logic [7:0]       tx;
        logic [7:0]       rx;
        logic [7:0]       rx_byte;
        logic [3:0]       edge_cnt;
        logic [3:0]       div_cnt;
        logic             sck;
        logic             sck_prev;
        logic             out_bit;
        logic             done;
    } spmsp_eng_s;

    typedef struct packed {
        logic [7:0] ctrl;
        logic       done;
        logic       write_collision_flag;
        logic       mode_fault_flag;
        logic       ovf;
        logic       full;
        logic [7:0] rx_buf;
        logic [7:0] tx_data;
        logic       load;
        logic       gie;
        logic       irq_en;
        logic       prio_lo;
        logic       prio_hi;
        logic       aw_got;
        logic       aw_ok;
        logic [7:0] aw_idx;
        logic       w_got;
        logic [7:0] wdata;
        logic       wstrb0;
        logic       bvalid;
        logic [1:0] bresp;
        logic       rvalid;
        logic [1:0] rresp;
        logic [7:0] rdata;
    } spmsp_regs_s;

endpackage

/* File: spmsp_sync.sv */
/*
 * spmsp_sync: two flip-flop synchroniser for pin inputs.
 * assumes: inputs are asynchronous to aclk.
 */
`timescale 1ns/1ps

module spmsp_sync #(
    parameter int W = 4
) (
    input  wire logic         aclk,
    input  wire logic         aresetn,
    input  wire logic         ce,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } spmsp_sync_s;

    spmsp_sync_s sync_reg;
    spmsp_sync_s sync_next;

    always_comb begin
        sync_next.s1 = din;
        sync_next.s2 = sync_reg.s1;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync_reg <= '0;
        end else if (ce) begin
            sync_reg <= sync_next;
        end
    end

    assign dout = sync_reg.s2;
endmodule // spmsp_sync

/* File: spmsp_top.sv */
/*
 * spmsp_top: byte-wide serial port, master or slave, with status flags,
 * receive buffer and gated four-level interrupt request, behind AXI4-Lite.
 * assumes: one clock aclk, synchronous active low reset, pins async.
 */
// The AXI4-Lite slave port was chosen for this implementation.
`timescale 1ns/1ps
`include "spmsp_params.svh"

module spmsp_top
    import spmsp_pkg::*;
#(
    parameter int ADDR_W = 12
) (
    input  wire logic              aclk,
    input  wire logic              aresetn,
    input  wire logic              ce,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    input  wire logic              sck_i,
    output logic                   sck_o,
    output logic                   sck_oe,
    input  wire logic              mosi_i,
    output logic                   mosi_o,
    output logic                   mosi_oe,
    input  wire logic              miso_i,
    output logic                   miso_o,
    output logic                   miso_oe,
    input  wire logic              ss_n_i,
    input  wire logic              irq_ack,
    output logic                   irq_req,
    output logic [1:0]             irq_level
);

    ////////////////////////////////////////////////////////////////////////////
    // pin synchroniser and shift engine

    spmsp_eng_if eng_if ();

    logic [3:0] pins_s;

    spmsp_sync #(
        .W (4)
    ) u_sync (
        .aclk    (aclk),
        .aresetn (aresetn),
        .ce      (ce),
        .din     ({sck_i, mosi_i, miso_i, ss_n_i}),
        .dout    (pins_s)
    );

    spmsp_engine u_engine (
        .aclk    (aclk),
        .aresetn (aresetn),
        .ce      (ce),
        .e       (eng_if.eng)
    );

    spmsp_regs_s r_reg;
    spmsp_regs_s r_next;

    assign eng_if.sck_s     = pins_s[3];
    assign eng_if.mosi_s    = pins_s[2];
    assign eng_if.miso_s    = pins_s[1];
    assign eng_if.ss_n_s    = pins_s[0];
    assign eng_if.on        = r_reg.ctrl[`SPMSP_CTRL_ON];
    assign eng_if.master    = r_reg.ctrl[`SPMSP_CTRL_ROLE];
    assign eng_if.clock_idle_level      = r_reg.ctrl[`SPMSP_CTRL_CLOCK_IDLE_LEVEL];
    assign eng_if.sample_edge_select      = r_reg.ctrl[`SPMSP_CTRL_SAMPLE_EDGE_SELECT];
    assign eng_if.ss_ignore = r_reg.ctrl[`SPMSP_CTRL_SSIGN];
    assign eng_if.low_bit_first      = r_reg.ctrl[`SPMSP_CTRL_LOW_BIT_FIRST];
    assign eng_if.rate      = r_reg.ctrl[`SPMSP_CTRL_RATE_HI:`SPMSP_CTRL_RATE_LO];
    assign eng_if.load      = r_reg.load;
    assign eng_if.load_data = r_reg.tx_data;

    assign sck_o   = eng_if.sck_o;
    assign sck_oe  = eng_if.sck_oe;
    assign mosi_o  = eng_if.mosi_o;
    assign mosi_oe = eng_if.mosi_oe;
    assign miso_o  = eng_if.miso_o;
    assign miso_oe = eng_if.miso_oe;

    ////////////////////////////////////////////////////////////////////////////
    // address decode

    function automatic logic idx_ok(input logic [ADDR_W-1:0] a);
        logic [7:0] i;
        i = a[9:2];
        return (a[ADDR_W-1:10] == '0) &&
               (i == `SPMSP_IDX_IRQ_GLOBAL || i == `SPMSP_IDX_IRQ_EN ||
                i == `SPMSP_IDX_PRIO_LO || i == `SPMSP_IDX_PRIO_HI ||
                i == `SPMSP_IDX_CTRL || i == `SPMSP_IDX_STAT ||
                i == `SPMSP_IDX_DATA);
    endfunction

    function automatic logic [7:0] status_byte(input spmsp_regs_s r,
                                               input logic busy);
        logic [7:0] s;
        s = `SPMSP_RST_BYTE;
        s[`SPMSP_STAT_DONE] = r.done;
        s[`SPMSP_STAT_WRITE_COLLISION_FLAG] = r.write_collision_flag;
        s[`SPMSP_STAT_MODE_FAULT_FLAG] = r.mode_fault_flag;
        s[`SPMSP_STAT_OVF]  = r.ovf;
        s[`SPMSP_STAT_FULL] = r.full;
        s[`SPMSP_STAT_BUSY] = busy;
        return s;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // bus handshakes

    assign s_axi_awready = !r_reg.aw_got && !r_reg.bvalid;
    assign s_axi_wready  = !r_reg.w_got && !r_reg.bvalid;
    assign s_axi_arready = !r_reg.rvalid;
    assign s_axi_bvalid  = r_reg.bvalid;
    assign s_axi_bresp   = r_reg.bresp;
    assign s_axi_rvalid  = r_reg.rvalid;
    assign s_axi_rresp   = r_reg.rresp;
    assign s_axi_rdata   = {24'h00_0000, r_reg.rdata};

    ////////////////////////////////////////////////////////////////////////////
    // next state

    logic       do_wr;
    logic       do_rd;
    logic [7:0] rd_idx;
    logic [7:0] wv;
    logic       clr_done;
    logic       clr_write_collision_flag;
    logic       clr_mode_fault_flag;
    logic       clr_ovf;
    logic       clr_full;
    logic       set_write_collision_flag;
    logic       set_mode_fault_flag;
    logic       data_rd;
    logic       data_wr;

    always_comb begin
        r_next      = r_reg;
        r_next.load = 1'b0;
        rd_idx      = s_axi_araddr[9:2];
        wv          = r_reg.wdata;
        clr_done    = irq_ack;
        clr_write_collision_flag    = 1'b0;
        clr_mode_fault_flag    = 1'b0;
        clr_ovf     = 1'b0;
        clr_full    = 1'b0;
        set_write_collision_flag    = 1'b0;
        data_rd     = 1'b0;
        data_wr     = 1'b0;

        if (s_axi_awvalid && s_axi_awready) begin
            r_next.aw_got = 1'b1;
            r_next.aw_ok  = idx_ok(s_axi_awaddr);
            r_next.aw_idx = s_axi_awaddr[9:2];
        end
        if (s_axi_wvalid && s_axi_wready) begin
            r_next.w_got  = 1'b1;
            r_next.wdata  = s_axi_wdata[7:0];
            r_next.wstrb0 = s_axi_wstrb[0];
        end
        if (r_reg.bvalid && s_axi_bready) begin
            r_next.bvalid = 1'b0;
        end
        if (r_reg.rvalid && s_axi_rready) begin
            r_next.rvalid = 1'b0;
        end

        // register write once address and data are both held
        do_wr = r_reg.aw_got && r_reg.w_got && !r_reg.bvalid;
        if (do_wr) begin
            r_next.aw_got = 1'b0;
            r_next.w_got  = 1'b0;
            r_next.bvalid = 1'b1;
            r_next.bresp  = r_reg.aw_ok ? `SPMSP_RESP_OKAY : `SPMSP_RESP_SLVERR;
            if (r_reg.aw_ok && r_reg.wstrb0) begin
                case (r_reg.aw_idx)
                    `SPMSP_IDX_IRQ_GLOBAL: begin
                        r_next.gie = wv[`SPMSP_GIE_BIT];
                    end
                    `SPMSP_IDX_IRQ_EN: begin
                        r_next.irq_en = wv[`SPMSP_IRQ_BIT];
                    end
                    `SPMSP_IDX_PRIO_LO: begin
                        r_next.prio_lo = wv[`SPMSP_IRQ_BIT];
                    end
                    `SPMSP_IDX_PRIO_HI: begin
                        r_next.prio_hi = wv[`SPMSP_IRQ_BIT];
                    end
                    `SPMSP_IDX_CTRL: begin
                        r_next.ctrl = wv;
                    end
                    `SPMSP_IDX_STAT: begin
                        clr_done = clr_done || !wv[`SPMSP_STAT_DONE];
                        clr_write_collision_flag = !wv[`SPMSP_STAT_WRITE_COLLISION_FLAG];
                        clr_mode_fault_flag = !wv[`SPMSP_STAT_MODE_FAULT_FLAG];
                        clr_ovf  = !wv[`SPMSP_STAT_OVF];
                        clr_full = !wv[`SPMSP_STAT_FULL];
                    end
                    `SPMSP_IDX_DATA: begin
                        data_wr = 1'b1;
                    end
                    default: begin
                        r_next.bresp = `SPMSP_RESP_SLVERR;
                    end
                endcase
            end
        end

        // data write: load when idle, collision when busy
        if (data_wr) begin
            if (eng_if.busy) begin
                set_write_collision_flag = 1'b1;
            end else begin
                clr_write_collision_flag       = 1'b1;
                r_next.tx_data = wv;
                r_next.load    = 1'b1;
            end
        end

        // register read
        do_rd = s_axi_arvalid && s_axi_arready;
        if (do_rd) begin
            r_next.rvalid = 1'b1;
            r_next.rresp  = `SPMSP_RESP_OKAY;
            r_next.rdata  = `SPMSP_RST_BYTE;
            if (!idx_ok(s_axi_araddr)) begin
                r_next.rresp = `SPMSP_RESP_SLVERR;
            end else begin
                case (rd_idx)
                    `SPMSP_IDX_IRQ_GLOBAL: begin
                        r_next.rdata[`SPMSP_GIE_BIT] = r_reg.gie;
                    end
                    `SPMSP_IDX_IRQ_EN: begin
                        r_next.rdata[`SPMSP_IRQ_BIT] = r_reg.irq_en;
                    end
                    `SPMSP_IDX_PRIO_LO: begin
                        r_next.rdata[`SPMSP_IRQ_BIT] = r_reg.prio_lo;
                    end
                    `SPMSP_IDX_PRIO_HI: begin
                        r_next.rdata[`SPMSP_IRQ_BIT] = r_reg.prio_hi;
                    end
                    `SPMSP_IDX_CTRL: begin
                        r_next.rdata = r_reg.ctrl;
                    end
                    `SPMSP_IDX_STAT: begin
                        r_next.rdata = status_byte(r_reg, eng_if.busy);
                    end
                    `SPMSP_IDX_DATA: begin
                        r_next.rdata = r_reg.rx_buf;
                        data_rd      = 1'b1;
                    end
                    default: begin
                        r_next.rresp = `SPMSP_RESP_SLVERR;
                    end
                endcase
            end
        end

        // mode fault: master, select pin used and driven low
        set_mode_fault_flag = r_reg.ctrl[`SPMSP_CTRL_ON] && r_reg.ctrl[`SPMSP_CTRL_ROLE] &&
                   !r_reg.ctrl[`SPMSP_CTRL_SSIGN] && !eng_if.ss_n_s;
        if (set_mode_fault_flag) begin
            r_next.ctrl[`SPMSP_CTRL_ON]   = 1'b0;
            r_next.ctrl[`SPMSP_CTRL_ROLE] = 1'b0;
        end

        if (eng_if.done) begin
            r_next.rx_buf = eng_if.rx_byte;
        end

        // flags: a set in the same cycle as a clear wins
        r_next.done = eng_if.done || (r_reg.done && !clr_done);
        r_next.write_collision_flag = set_write_collision_flag || (r_reg.write_collision_flag && !clr_write_collision_flag);
        r_next.mode_fault_flag = set_mode_fault_flag || (r_reg.mode_fault_flag && !clr_mode_fault_flag);
        r_next.ovf  = (eng_if.done && r_reg.full) ||
                      (r_reg.ovf && !clr_ovf && !data_rd);
        r_next.full = eng_if.done ||
                      (r_reg.full && !clr_full && !data_rd);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            r_reg <= '0;
        end else if (ce) begin
            r_reg <= r_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // interrupt request and level

    assign irq_req   = r_reg.gie && r_reg.irq_en &&
                       (r_reg.done || r_reg.mode_fault_flag);
    assign irq_level = {r_reg.prio_hi, r_reg.prio_lo};

endmodule // spmsp_top

/* File: tb.sv */
/* tb: register bus master driving the serial port against a slave peer.
   assumes: peer answers 3C, clock idle low, sampling on the first edge. */
`timescale 1ns/1ps
module tb;
    logic        aclk = 0, aresetn = 0, ce = 1, s_axi_awvalid = 0, s_axi_wvalid = 0;
    logic        s_axi_bready = 1, s_axi_arvalid = 0, s_axi_rready = 1, ss_n_i = 1;
    logic        irq_ack = 0, sel_n = 1, s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic        s_axi_arready, s_axi_rvalid, sck_o, sck_oe, mosi_o, mosi_oe;
    logic        miso_o, miso_oe, irq_req, msck = 0, mbit = 0;
    logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata;
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic [1:0]  s_axi_bresp, s_axi_rresp, irq_level, resp;
    logic [7:0]  rx, v;
    wire         pmiso;
    wire         sck_i = sck_oe ? sck_o : msck;
    wire         mosi_i = mosi_oe ? mosi_o : mbit;
    wire         miso_i = miso_oe ? miso_o : pmiso;
    int          err_total = 0, comparisons = 0;
    localparam logic [11:0] GIE = 12'h2A0, IEN = 12'h2A4, PLO = 12'h2E8, PHI = 12'h2EC;
    localparam logic [11:0] CTL = 12'h2F0, STA = 12'h2F4, DAT = 12'h2F8;
    localparam logic [7:0]  SIN = 8'h69;
    spmsp_top spmsp_top_inst (.*);
    spmsp_peer spmsp_peer_inst (.sck(sck_i), .mosi(mosi_i), .sel_n(sel_n), .tx(8'h3C),
                                .miso(pmiso), .rx(rx));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h00_0000, d};
        s_axi_awvalid <= 1;
        s_axi_wvalid <= 1;
        fork
            begin
                do @(negedge aclk); while (!s_axi_awready);
                @(posedge aclk) s_axi_awvalid <= 0;
            end
            begin
                do @(negedge aclk); while (!s_axi_wready);
                @(posedge aclk) s_axi_wvalid <= 0;
            end
        join
        do @(negedge aclk); while (!s_axi_bvalid);
        resp = s_axi_bresp;
        @(posedge aclk);
    endtask
    task automatic rd(input logic [11:0] a, output logic [7:0] d);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1;
        do @(negedge aclk); while (!s_axi_arready);
        @(posedge aclk) s_axi_arvalid <= 0;
        do @(negedge aclk); while (!s_axi_rvalid);
        d = s_axi_rdata[7:0];
        resp = s_axi_rresp;
        @(posedge aclk);
    endtask
    task automatic xfer(input logic [7:0] d, input logic col);
        sel_n <= 0;
        wr(DAT, d);
        do rd(STA, v); while (!v[2]);
        if (col) wr(DAT, 8'hFF);
        do rd(STA, v); while (v[2]);
        sel_n <= 1;
        @(posedge aclk);
    endtask
    task automatic t_reset;
        for (int i = 0; i < 3; i++) begin
            rd(12'(CTL + 4 * i), v);
            chk(v, 8'h00);
        end
        rd(12'h000, v);
        chk({6'h00, resp}, 8'h02);
        wr(12'h000, 8'hFF);
        chk({6'h00, resp}, 8'h02);
        s_axi_wstrb <= 4'h0;
        wr(CTL, 8'hFF);
        chk({6'h00, resp}, 8'h00);
        s_axi_wstrb <= 4'hF;
        rd(CTL, v);
        chk(v, 8'h00);
    endtask
    task automatic t_master;
        wr(GIE, 8'h80);
        wr(IEN, 8'h10);
        wr(PLO, 8'h10);
        wr(PHI, 8'h10);
        chk({6'h00, irq_level}, 8'h03);
        wr(CTL, 8'hC3);
        xfer(8'hA5, 0);
        chk(rx, 8'hA5);
        rd(STA, v);
        chk(v, 8'h88);
        chk({7'h00, irq_req}, 8'h01);
        xfer(8'h5A, 1);
        chk(rx, 8'h5A);
        rd(STA, v);
        chk(v, 8'hD8);
        rd(DAT, v);
        chk(v, 8'h3C);
        rd(STA, v);
        chk(v, 8'hC0);
        irq_ack <= 1;
        @(posedge aclk) irq_ack <= 0;
        rd(STA, v);
        chk(v, 8'h40);
        chk({7'h00, irq_req}, 8'h00);
        wr(STA, 8'h00);
        rd(STA, v);
        chk(v, 8'h00);
        wr(CTL, 8'hC7);
        xfer(8'h01, 0);
        chk(rx, 8'h80);
    endtask
    task automatic t_fault;
        ss_n_i <= 0;
        do rd(STA, v); while (!v[5]);
        ss_n_i <= 1;
        rd(CTL, v);
        chk(v, 8'h07);
        wr(STA, 8'h00);
        rd(STA, v);
        chk(v, 8'h00);
    endtask
    task automatic t_slave;
        wr(CTL, 8'h80);
        wr(DAT, 8'h96);
        ss_n_i <= 0;
        for (int i = 7; i >= 0; i--) begin
            mbit <= SIN[i];
            repeat (8) @(posedge aclk);
            msck <= 1;
            v[i] = miso_o;
            repeat (8) @(posedge aclk);
            msck <= 0;
        end
        repeat (8) @(posedge aclk);
        chk({7'h00, miso_oe}, 8'h01);
        ss_n_i <= 1;
        chk(v, 8'h96);
        rd(DAT, v);
        chk(v, SIN);
    endtask
    task automatic conclude;
        if (err_total == 0 && comparisons > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        forever #20 aclk = ~aclk;
    end
    initial begin
        repeat (20000) @(posedge aclk);
        err_total++;
        conclude();
    end
    initial begin
        repeat (5) @(posedge aclk);
        aresetn <= 1;
        @(posedge aclk);
        t_reset();
        t_master();
        t_fault();
        t_slave();
        conclude();
    end
endmodule // tb
